// [core/pso_pkg.sv]
// Purpose: Constants and types for the programmable status output select block
// Assumes: One 40 MHz clock, synchronous active-high reset
// Notes: Selection codes are 5 bits wide; codes above 18 are treated as no function
//
// Functional notes
// R1: Two relay groups, one open-collector and one fast terminal, each with own code.
// R2: Fast terminal works either as pulse train output or plain on/off output.
// R3: One code may feed several terminals, each following it independently.
// R4: Code 0 gives no function; terminal stays off.
// R5: Code 1 asserts while running with output frequency.
// R6: Code 2 asserts while running forward with output frequency.
// R7: Code 3 asserts while running reverse with output frequency.
// R8: Code 4 asserts while jogging with output frequency.
// R9: Code 5 asserts while the drive is in fault.
// R10: Codes 6, 7, 8 route first level, second level and reached flags.
// R11: Code 9 asserts when output and reference frequency are both zero.
// R12: Code 10 asserts when running frequency reaches the upper limit.
// R13: Code 11 asserts when running frequency reaches the lower limit.
// R14: Code 12 asserts when powers are up, no protection active, ready to run.
// R15: Code 13 asserts during motor pre-excitation.
// R16: Code 14 asserts on overload pre-alarm after its duration.
// R17: Code 15 asserts on underload pre-alarm after its duration.
// R18: Code 17 asserts when the step sequencer completes a cycle.
// R19: Communication code drives terminal from the Modbus-written bit, on when 1.
// R20: Code 16 asserts when the step sequencer completes a stage.
// R21: Outputs are registered every cycle and all off after reset.
package pso_pkg;

  localparam int SEL_W = 5;
  localparam int NUM_TERM = 4;

  // Terminal indices into the terminal state and Modbus vectors
  localparam int TERM_RELAY1 = 0;
  localparam int TERM_RELAY2 = 1;
  localparam int TERM_OC = 2;
  localparam int TERM_FAST = 3;

  // Output function selection codes
  localparam logic [SEL_W-1:0] SEL_NONE = 5'h00;
  localparam logic [SEL_W-1:0] SEL_RUN = 5'h01;
  localparam logic [SEL_W-1:0] SEL_FWD = 5'h02;
  localparam logic [SEL_W-1:0] SEL_REV = 5'h03;
  localparam logic [SEL_W-1:0] SEL_JOG = 5'h04;
  localparam logic [SEL_W-1:0] SEL_FAULT = 5'h05;
  localparam logic [SEL_W-1:0] SEL_FDET1 = 5'h06;
  localparam logic [SEL_W-1:0] SEL_FDET2 = 5'h07;
  localparam logic [SEL_W-1:0] SEL_FREACH = 5'h08;
  localparam logic [SEL_W-1:0] SEL_ZERO = 5'h09;
  localparam logic [SEL_W-1:0] SEL_UPLIM = 5'h0A;
  localparam logic [SEL_W-1:0] SEL_LOLIM = 5'h0B;
  localparam logic [SEL_W-1:0] SEL_READY = 5'h0C;
  localparam logic [SEL_W-1:0] SEL_PREEXC = 5'h0D;
  localparam logic [SEL_W-1:0] SEL_OVLD = 5'h0E;
  localparam logic [SEL_W-1:0] SEL_UNLD = 5'h0F;
  localparam logic [SEL_W-1:0] SEL_STAGE = 5'h10;
  localparam logic [SEL_W-1:0] SEL_CYCLE = 5'h11;
  localparam logic [SEL_W-1:0] SEL_COMM = 5'h12;

  // Fast terminal mode
  typedef enum logic [0:0] {
    PSO_MODE_DIGITAL = 1'b0,
    PSO_MODE_PULSE = 1'b1
  } pso_mode_t;

  // Internal drive status conditions
  typedef struct packed {
    logic running;
    logic has_freq;
    logic reverse;
    logic jogging;
    logic fault;
    logic freq_level_detect_first;
    logic freq_level_detect_second;
    logic freq_reached;
    logic out_freq_zero;
    logic ref_freq_zero;
    logic upper_limit;
    logic lower_limit;
    logic main_power_ok;
    logic ctrl_power_ok;
    logic protect_active;
    logic pre_excite;
    logic overload_alarm;
    logic underload_alarm;
    logic stage_done;
    logic cycle_done;
  } pso_status_t;

  // Registered terminal levels
  typedef struct packed {
    logic [NUM_TERM-1:0] term;
  } pso_state_t;

  localparam pso_state_t PSO_RESET = '{term: 4'h0};

endpackage

// [core/pso_output_select.sv]
// Purpose: Routes drive status conditions onto four output terminals by selection code
// Assumes: Status inputs and select codes come from logic on i_clk
// Notes: Pulse train generation lives elsewhere; this block only hands the pulse source through
`timescale 1ns/10ps
module pso_output_select (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Drive status
  input wire pso_pkg::pso_status_t i_status,
  // Per-terminal function selection
  input wire logic [pso_pkg::SEL_W-1:0] i_sel_relay1,
  input wire logic [pso_pkg::SEL_W-1:0] i_sel_relay2,
  input wire logic [pso_pkg::SEL_W-1:0] i_sel_oc,
  input wire logic [pso_pkg::SEL_W-1:0] i_sel_fast,
  // Modbus virtual terminal bits, one per terminal
  input wire logic [pso_pkg::NUM_TERM-1:0] i_comm_bits,
  // Fast terminal mode and pulse source
  input wire pso_pkg::pso_mode_t i_fast_mode,
  input wire logic i_pulse_src,
  // Terminals
  output logic o_relay1,
  output logic o_relay2,
  output logic o_oc,
  output logic o_fast_pulse_terminal
);

  // ------------------------------------------------------------
  // Motion conditions
  // ------------------------------------------------------------
  // Direction is left open here; the forward and reverse codes narrow it
  function automatic logic cond_running(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.running & st.has_freq;
    return v;
  endfunction

  function automatic logic cond_forward(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = cond_running(st) & ~st.reverse;
    return v;
  endfunction

  function automatic logic cond_reverse(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = cond_running(st) & st.reverse;
    return v;
  endfunction

  // Jogging stands on its own, whatever the running flag says
  function automatic logic cond_jogging(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.jogging & st.has_freq;
    return v;
  endfunction

  // ------------------------------------------------------------
  // Fault and frequency levels
  // ------------------------------------------------------------
  function automatic logic cond_fault(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.fault;
    return v;
  endfunction

  // Thresholds live in the detection logic; only the finished flags arrive here
  function automatic logic cond_level_first(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.freq_level_detect_first;
    return v;
  endfunction

  function automatic logic cond_level_second(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.freq_level_detect_second;
    return v;
  endfunction

  function automatic logic cond_reached(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.freq_reached;
    return v;
  endfunction

  // Both the actual and the commanded frequency must be zero, not just one
  function automatic logic cond_zero_speed(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.out_freq_zero & st.ref_freq_zero;
    return v;
  endfunction

  function automatic logic cond_upper_limit(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.upper_limit;
    return v;
  endfunction

  function automatic logic cond_lower_limit(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.lower_limit;
    return v;
  endfunction

  // ------------------------------------------------------------
  // Readiness and load alarms
  // ------------------------------------------------------------
  // A tripped protection blocks readiness even with both supplies up
  function automatic logic cond_ready(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.main_power_ok & st.ctrl_power_ok & ~st.protect_active;
    return v;
  endfunction

  function automatic logic cond_pre_excite(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.pre_excite;
    return v;
  endfunction

  // Pre-alarm timing is done upstream; the flags already include their delay
  function automatic logic cond_overload(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.overload_alarm;
    return v;
  endfunction

  function automatic logic cond_underload(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.underload_alarm;
    return v;
  endfunction

  // ------------------------------------------------------------
  // Step sequencer
  // ------------------------------------------------------------
  // Pulse or level is passed on as the sequencer produces it
  function automatic logic cond_stage_done(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.stage_done;
    return v;
  endfunction

  function automatic logic cond_cycle_done(
    input pso_pkg::pso_status_t st
  );
    logic v;
    v = st.cycle_done;
    return v;
  endfunction

  // ------------------------------------------------------------
  // Condition table
  // ------------------------------------------------------------
  // One bit per selection code; reserved codes stay low and act as no function
  localparam int CODE_CNT = 1 << pso_pkg::SEL_W;
  typedef logic [CODE_CNT-1:0] pso_cond_vec_t;

  function automatic pso_cond_vec_t cond_table(
    input pso_pkg::pso_status_t st
  );
    pso_cond_vec_t t;
    t = '0;
    t[pso_pkg::SEL_NONE] = 1'b0; // R4
    t[pso_pkg::SEL_RUN] = cond_running(st); // R5
    t[pso_pkg::SEL_FWD] = cond_forward(st); // R6
    t[pso_pkg::SEL_REV] = cond_reverse(st); // R7
    t[pso_pkg::SEL_JOG] = cond_jogging(st); // R8
    t[pso_pkg::SEL_FAULT] = cond_fault(st); // R9
    t[pso_pkg::SEL_FDET1] = cond_level_first(st); // R10
    t[pso_pkg::SEL_FDET2] = cond_level_second(st); // R10
    t[pso_pkg::SEL_FREACH] = cond_reached(st); // R10
    t[pso_pkg::SEL_ZERO] = cond_zero_speed(st); // R11
    t[pso_pkg::SEL_UPLIM] = cond_upper_limit(st); // R12
    t[pso_pkg::SEL_LOLIM] = cond_lower_limit(st); // R13
    t[pso_pkg::SEL_READY] = cond_ready(st); // R14
    t[pso_pkg::SEL_PREEXC] = cond_pre_excite(st); // R15
    t[pso_pkg::SEL_OVLD] = cond_overload(st); // R16
    t[pso_pkg::SEL_UNLD] = cond_underload(st); // R17
    t[pso_pkg::SEL_STAGE] = cond_stage_done(st); // R20
    t[pso_pkg::SEL_CYCLE] = cond_cycle_done(st); // R18
    // The communication code differs per terminal, so it stays out of the table
    return t;
  endfunction

  // ------------------------------------------------------------
  // Terminal level
  // ------------------------------------------------------------
  // Codes past the communication code are reserved and never drive a terminal
  function automatic logic code_defined(
    input logic [pso_pkg::SEL_W-1:0] sel
  );
    logic v;
    v = (sel <= pso_pkg::SEL_COMM);
    return v;
  endfunction

  // Shared by all terminals, the fast one in digital mode only, so that equal codes give equal behaviour
  function automatic logic term_level(
    input logic [pso_pkg::SEL_W-1:0] sel,
    input pso_cond_vec_t tbl,
    input logic comm
  );
    logic v;
    if (!code_defined(sel)) begin
      v = 1'b0; // R4
    end else if (sel == pso_pkg::SEL_COMM) begin
      v = comm; // R19
    end else begin
      v = tbl[sel]; // R3
    end
    return v;
  endfunction

  // ------------------------------------------------------------
  // Fast terminal
  // ------------------------------------------------------------
  // In pulse mode the code is ignored and the pulse source passes straight through
  function automatic logic fast_level(
    input pso_pkg::pso_mode_t mode,
    input logic [pso_pkg::SEL_W-1:0] sel,
    input pso_cond_vec_t tbl,
    input logic comm,
    input logic pulse
  );
    logic v;
    if (mode == pso_pkg::PSO_MODE_PULSE) begin
      v = pulse; // R2
    end else begin
      v = term_level(sel, tbl, comm); // R2
    end
    return v;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  pso_pkg::pso_state_t state_r;
  pso_pkg::pso_state_t state_nxt;

  // The condition table is built once and shared by all four terminals
  always_comb begin
    pso_cond_vec_t tbl;
    tbl = cond_table(i_status);
    state_nxt = state_r;
    // Each terminal decodes its own code independently
    state_nxt.term[pso_pkg::TERM_RELAY1] =
      term_level(i_sel_relay1, tbl, i_comm_bits[pso_pkg::TERM_RELAY1]); // R1 R3
    state_nxt.term[pso_pkg::TERM_RELAY2] =
      term_level(i_sel_relay2, tbl, i_comm_bits[pso_pkg::TERM_RELAY2]); // R1 R3
    state_nxt.term[pso_pkg::TERM_OC] =
      term_level(i_sel_oc, tbl, i_comm_bits[pso_pkg::TERM_OC]); // R1 R3
    state_nxt.term[pso_pkg::TERM_FAST] =
      fast_level(i_fast_mode, i_sel_fast, tbl, i_comm_bits[pso_pkg::TERM_FAST],
                 i_pulse_src); // R1 R2
  end

  // One register stage: a terminal shows what its inputs held one edge before
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= pso_pkg::PSO_RESET; // R21
    end else begin
      state_r <= state_nxt; // R21
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Straight from the state flops, nothing after them
  assign o_relay1 = state_r.term[pso_pkg::TERM_RELAY1];
  assign o_relay2 = state_r.term[pso_pkg::TERM_RELAY2];
  assign o_oc = state_r.term[pso_pkg::TERM_OC];
  assign o_fast_pulse_terminal = state_r.term[pso_pkg::TERM_FAST];

endmodule

// [testbench/pso_chk.sv]
// Purpose: Terminal routing checks
// Assumes: Bound to pso_output_select
// Notes: Terminal follows its select one cycle later
`timescale 1ns/10ps
module pso_chk (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire pso_pkg::pso_status_t i_status,
  input wire logic [pso_pkg::SEL_W-1:0] i_sel_relay1,
  input wire logic [pso_pkg::SEL_W-1:0] i_sel_relay2,
  input wire logic [pso_pkg::SEL_W-1:0] i_sel_oc,
  input wire logic [pso_pkg::SEL_W-1:0] i_sel_fast,
  input wire logic [pso_pkg::NUM_TERM-1:0] i_comm_bits,
  input wire pso_pkg::pso_mode_t i_fast_mode,
  input wire logic i_pulse_src,
  input wire logic o_relay1,
  input wire logic o_relay2,
  input wire logic o_oc,
  input wire logic o_fast_pulse_terminal
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  pso_pkg::pso_status_t s;
  assign s = i_status;
  property p_none; i_sel_relay1 == 5'h00 |=> !o_relay1; endproperty
  a_none: assert property (p_none) else $error("relay1 on");
  property p_run; i_sel_relay1 == 5'h01 |=> o_relay1 == $past(s.running & s.has_freq); endproperty
  a_run: assert property (p_run) else $error("relay1 run");
  property p_fwd;
    i_sel_relay2 == 5'h02 |=> o_relay2 == $past(s.running & s.has_freq & !s.reverse);
  endproperty
  a_fwd: assert property (p_fwd) else $error("relay2 fwd");
  property p_zero; i_sel_oc == 5'h09 |=> o_oc == $past(s.out_freq_zero & s.ref_freq_zero); endproperty
  a_zero: assert property (p_zero) else $error("oc zero");
  property p_rdy; i_sel_oc == 5'h0C && s.protect_active |=> !o_oc; endproperty
  a_rdy: assert property (p_rdy) else $error("oc ready");
  property p_flt; i_sel_relay2 == 5'h05 |=> o_relay2 == $past(s.fault); endproperty
  a_flt: assert property (p_flt) else $error("relay2 fault");
  property p_comm; i_sel_relay2 == 5'h12 |=> o_relay2 == $past(i_comm_bits[1]); endproperty
  a_comm: assert property (p_comm) else $error("relay2 comm");
  property p_puls; i_fast_mode == pso_pkg::PSO_MODE_PULSE |=> o_fast_pulse_terminal == $past(i_pulse_src); endproperty
  a_puls: assert property (p_puls) else $error("fast pulse");
endmodule
bind pso_output_select pso_chk chk_u (.*);

// [testbench/pso_load_model.sv]
// Purpose: External loads on the four terminals
// Assumes: Terminals are active high levels
// Notes: Loads only follow the terminal levels
`timescale 1ns/10ps
module pso_load_model (
  input wire logic i_clk,
  input wire logic [3:0] i_term,
  output logic [3:0] o_energised
);
  always_ff @(posedge i_clk) o_energised <= i_term;
endmodule

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for terminal routing
// Assumes: Inputs driven at rising edge
// Notes: Order in o is relay1, relay2, oc, fast
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; $display("FAIL %0t mismatch", $time); end end
module tb_top;
  logic i_clk = 0, i_sys_rst = 1, i_pulse_src = 0;
  pso_pkg::pso_status_t i_status = '0;
  logic [4:0] s1 = '0, s2 = '0, s3 = '0, s4 = '0;
  logic [3:0] i_comm_bits = '0;
  wire [3:0] o, ld;
  pso_pkg::pso_mode_t i_fast_mode = pso_pkg::PSO_MODE_DIGITAL;
  int mismatches = 0, check_count = 0, cyc = 0;
  always #12.5 i_clk = ~i_clk;
  pso_output_select dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_status(i_status),
    .i_sel_relay1(s1), .i_sel_relay2(s2), .i_sel_oc(s3), .i_sel_fast(s4),
    .i_comm_bits(i_comm_bits), .i_fast_mode(i_fast_mode), .i_pulse_src(i_pulse_src),
    .o_relay1(o[3]), .o_relay2(o[2]), .o_oc(o[1]), .o_fast_pulse_terminal(o[0]));
  pso_load_model load_u (.i_clk(i_clk), .i_term(o), .o_energised(ld));
  task automatic tally_and_finish;
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic set4(input logic [19:0] c, input logic [19:0] st, input logic [3:0] cb,
                      input logic [3:0] ex);
    @(posedge i_clk);
    {s1, s2, s3, s4} <= c;
    i_status <= st;
    i_comm_bits <= cb;
    @(posedge i_clk);
    #1 `CHK(o, ex)
  endtask
  task automatic run(input logic [4:0] c, input logic [19:0] st, input logic [3:0] ex);
    set4({4{c}}, st, 4'h0, ex);
  endtask
  task automatic one(input logic [4:0] c, input logic [19:0] m);
    run(c, m, 4'hF);
    run(c, ~m, 4'h0);
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 1000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1 `CHK(o, 4'h0)
    run(5'h00, 20'hFFFFF, 4'h0);
    run(5'h13, 20'hFFFFF, 4'h0);
    run(5'h01, 20'hC0000, 4'hF);
    run(5'h01, 20'h80000, 4'h0);
    run(5'h02, 20'hC0000, 4'hF);
    run(5'h02, 20'hE0000, 4'h0);
    run(5'h03, 20'hE0000, 4'hF);
    run(5'h03, 20'hC0000, 4'h0);
    run(5'h04, 20'h50000, 4'hF);
    run(5'h04, 20'h10000, 4'h0);
    one(5'h05, 20'h08000);
    one(5'h06, 20'h04000);
    one(5'h07, 20'h02000);
    one(5'h08, 20'h01000);
    run(5'h09, 20'h00C00, 4'hF);
    run(5'h09, 20'hFF7FF, 4'h0);
    one(5'h0A, 20'h00200);
    one(5'h0B, 20'h00100);
    run(5'h0C, 20'h000C0, 4'hF);
    run(5'h0C, 20'h000E0, 4'h0);
    one(5'h0D, 20'h00010);
    one(5'h0E, 20'h00008);
    one(5'h0F, 20'h00004);
    one(5'h10, 20'h00002);
    one(5'h11, 20'h00001);
    set4({4{5'h12}}, 20'h0, 4'h5, 4'hA);
    set4({5'h05, 5'h00, 5'h09, 5'h12}, 20'h08C00, 4'h8, 4'hB);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      i_fast_mode <= pso_pkg::PSO_MODE_PULSE;
      i_pulse_src <= k[0];
      @(posedge i_clk);
      #1 `CHK(o[0], k[0])
    end
    @(posedge i_clk);
    i_fast_mode <= pso_pkg::PSO_MODE_DIGITAL;
    run(5'h05, 20'h00000, 4'h0);
    run(5'h05, 20'h08000, 4'hF);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    #1 `CHK(ld, 4'hF)
    @(posedge i_clk);
    #1 `CHK(o, 4'h0)
    @(posedge i_clk);
    i_sys_rst <= 1'b0;
    run(5'h05, 20'h08000, 4'hF);
    tally_and_finish();
  end
endmodule
